//--- hw/hssc_pkg.sv
package hssc_pkg;

  // Clock and filter timing
  localparam int CLK_MHZ          = 125;
  localparam int OC_FILT_NS       = 16000;
  localparam int OC_FILT_CYC      = OC_FILT_NS * CLK_MHZ / 1000;
  localparam int OL_FILT_NS       = 64000;
  localparam int OL_FILT_CYC      = OL_FILT_NS * CLK_MHZ / 1000;

  // PWM: 256 steps per period; 200 Hz = 5000 us, 400 Hz = 2500 us
  localparam int PWM_STEPS        = 256;
  localparam int PWM_SLOW_US      = 5000;
  localparam int PWM_FAST_US      = 2500;
  localparam logic [11:0] PWM_SLOW_STEP_CYC =
    12'(PWM_SLOW_US * CLK_MHZ / PWM_STEPS);
  localparam logic [11:0] PWM_FAST_STEP_CYC =
    12'(PWM_FAST_US * CLK_MHZ / PWM_STEPS);

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL_A   = 8'h00;
  localparam logic [7:0] OFF_CTRL_B   = 8'h04;
  localparam logic [7:0] OFF_SUP_CFG  = 8'h08;
  localparam logic [7:0] OFF_DUTY1    = 8'h0c;
  localparam logic [7:0] OFF_DUTY2    = 8'h10;
  localparam logic [7:0] OFF_FREQ     = 8'h14;
  localparam logic [7:0] OFF_OC_STAT  = 8'h18;
  localparam logic [7:0] OFF_OL_STAT  = 8'h1c;
  localparam logic [7:0] OFF_SUP_STAT = 8'h20;
  localparam logic [7:0] OFF_STATE    = 8'h24;

  // Field positions
  localparam int CTRL_LO_POS      = 0;
  localparam int CTRL_HI_POS      = 4;
  localparam int SUP_OV_EN_BIT    = 0;
  localparam int SUP_UV_EN_BIT    = 1;
  localparam int SUP_REC_EN_BIT   = 2;
  localparam int SUP_OV_FLAG_BIT  = 0;
  localparam int SUP_UV_FLAG_BIT  = 1;
  localparam int STATE_FAULT_BIT  = 4;
  localparam int STATE_LOCK_BIT   = 5;

  // Reset values
  localparam logic [2:0] SUP_CFG_RST = 3'h3;
  localparam logic [7:0] DUTY_RST    = 8'h00;

  // Channel source codes
  localparam logic [2:0] CFG_OFF  = 3'h0;
  localparam logic [2:0] CFG_ON   = 3'h1;
  localparam logic [2:0] CFG_TMR1 = 3'h2;
  localparam logic [2:0] CFG_TMR2 = 3'h3;
  localparam logic [2:0] CFG_PWM1 = 3'h4;
  localparam logic [2:0] CFG_PWM2 = 3'h5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESTART,
    MODE_FAILSAFE
  } hssc_mode_t;

endpackage : hssc_pkg

//--- hw/hssc_top.sv
// What this block does
// - Output setup is writable only in Normal mode; locked in Stop/Sleep.
// - Entering Restart or Fail-Safe forces all four outputs off.
// - Enabled supply overvoltage turns outputs off until it clears.
// - Enabled supply undervoltage turns outputs off until it clears.
// - Without recovery enable, outputs stay off and control fields clear.
// - Supply faults set only their own supply status bit.
// - Overcurrent lasting the 16 us filter switches the output off.
// - Overcurrent shutdown sets channel flag and clears its field to 000.
// - Overcurrent flags are sticky; only the controller clears them.
// - Undercurrent lasting 64 us while on sets open-load flag; output stays.
// - Open-load flags stay set until cleared by a register write.
// - Outputs and all protections keep working in Stop and Sleep.
// - Outputs forced off by Restart/Fail-Safe can be re-enabled by write.
// - Two PWM generators, each with its own 8-bit duty register.
// - Each generator selects 200 Hz or 400 Hz independently.
// - PWM appears at once when a channel is assigned to a generator.
// - Each output follows one source: on bit, timer 1/2, PWM 1/2.
`timescale 1ns/1ps

module hssc_top #(
  parameter int P_OL_FILT_CYC = hssc_pkg::OL_FILT_CYC
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire hssc_pkg::hssc_mode_t i_dev_mode,
  input  wire logic               i_supply_ov,
  input  wire logic               i_supply_uv,
  input  wire logic [3:0]         i_overcurrent,
  input  wire logic [3:0]         i_undercurrent,
  input  wire logic               i_timer1,
  input  wire logic               i_timer2,
  output logic [3:0]              o_switched_output,
  input  wire logic [7:0]         i_s_axi_awaddr,
  input  wire logic               i_s_axi_awvalid,
  output logic                    o_s_axi_awready,
  input  wire logic [31:0]        i_s_axi_wdata,
  input  wire logic [3:0]         i_s_axi_wstrb,
  input  wire logic               i_s_axi_wvalid,
  output logic                    o_s_axi_wready,
  output logic [1:0]              o_s_axi_bresp,
  output logic                    o_s_axi_bvalid,
  input  wire logic               i_s_axi_bready,
  input  wire logic [7:0]         i_s_axi_araddr,
  input  wire logic               i_s_axi_arvalid,
  output logic                    o_s_axi_arready,
  output logic [31:0]             o_s_axi_rdata,
  output logic [1:0]              o_s_axi_rresp,
  output logic                    o_s_axi_rvalid,
  input  wire logic               i_s_axi_rready
);

  typedef struct packed {
    logic [1:0]        ov_s;
    logic [1:0]        uv_s;
    logic [1:0][3:0]   oc_s;
    logic [1:0][3:0]   uc_s;
    logic [3:0][2:0]   cfg;
    logic [2:0]        sup_cfg;
    logic [1:0][7:0]   duty;
    logic [1:0]        freq_fast;
    logic [1:0][11:0]  pre;
    logic [1:0][7:0]   step;
    logic [1:0]        pwm_out;
    logic [3:0][10:0]  oc_cnt;
    logic [3:0][12:0]  ol_cnt;
    logic [3:0]        oc_flag;
    logic [3:0]        ol_flag;
    logic [1:0]        sup_flag;
    logic              fault_q;
    logic [3:0]        out;
    logic              aw_got;
    logic [7:0]        waddr;
    logic              w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awrdy;
    logic              wrdy;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arrdy;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } hssc_state_t;

  hssc_state_t r;
  hssc_state_t n;

  logic [10:0] oc_lim;
  logic [12:0] ol_lim;
  logic        normal;
  logic        forced;
  logic        fault;
  logic        src;
  logic        wipe;
  logic [11:0] step_lim;
  logic [3:0]  oc_clr;
  logic [3:0]  ol_clr;
  logic [1:0]  sup_clr;
  logic [7:0]  raddr;

  assign oc_lim = 11'(hssc_pkg::OC_FILT_CYC - 1);
  assign ol_lim = 13'(P_OL_FILT_CYC - 1);

  always_comb
  begin
    n       = r;
    src     = 1'b0;
    step_lim = hssc_pkg::PWM_SLOW_STEP_CYC;
    oc_clr  = 4'h0;
    ol_clr  = 4'h0;
    sup_clr = 2'h0;
    raddr   = i_s_axi_araddr;

    // Two-stage synchronisers for the analog comparator indications
    n.ov_s = {r.ov_s[0], i_supply_ov};
    n.uv_s = {r.uv_s[0], i_supply_uv};
    n.oc_s = {r.oc_s[0], i_overcurrent};
    n.uc_s = {r.uc_s[0], i_undercurrent};

    normal = (i_dev_mode == hssc_pkg::MODE_NORMAL);
    forced = (i_dev_mode == hssc_pkg::MODE_RESTART) ||
             (i_dev_mode == hssc_pkg::MODE_FAILSAFE);

    // Bus write: address and data may arrive in either order
    if (i_s_axi_awvalid && r.awrdy)
    begin
      n.aw_got = 1'b1;
      n.waddr  = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && r.wrdy)
    begin
      n.w_got = 1'b1;
      n.wdata = i_s_axi_wdata;
      n.wstrb = i_s_axi_wstrb;
    end
    if (r.bvalid && i_s_axi_bready)
      n.bvalid = 1'b0;

    if (r.aw_got && r.w_got && !r.bvalid)
    begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = hssc_pkg::RESP_OKAY;
      // Setup writes outside Normal are dropped but still answered OKAY
      if (r.waddr == hssc_pkg::OFF_CTRL_A)
      begin
        if (normal && r.wstrb[0])
        begin
          n.cfg[0] = r.wdata[hssc_pkg::CTRL_LO_POS +: 3];
          n.cfg[1] = r.wdata[hssc_pkg::CTRL_HI_POS +: 3];
        end
      end
      else if (r.waddr == hssc_pkg::OFF_CTRL_B)
      begin
        if (normal && r.wstrb[0])
        begin
          n.cfg[2] = r.wdata[hssc_pkg::CTRL_LO_POS +: 3];
          n.cfg[3] = r.wdata[hssc_pkg::CTRL_HI_POS +: 3];
        end
      end
      else if (r.waddr == hssc_pkg::OFF_SUP_CFG)
      begin
        if (normal && r.wstrb[0])
          n.sup_cfg = r.wdata[2:0];
      end
      else if (r.waddr == hssc_pkg::OFF_DUTY1)
      begin
        if (normal && r.wstrb[0])
          n.duty[0] = r.wdata[7:0];
      end
      else if (r.waddr == hssc_pkg::OFF_DUTY2)
      begin
        if (normal && r.wstrb[0])
          n.duty[1] = r.wdata[7:0];
      end
      else if (r.waddr == hssc_pkg::OFF_FREQ)
      begin
        if (normal && r.wstrb[0])
          n.freq_fast = r.wdata[1:0];
      end
      else if (r.waddr == hssc_pkg::OFF_OC_STAT)
      begin
        if (r.wstrb[0])
          oc_clr = r.wdata[3:0];
      end
      else if (r.waddr == hssc_pkg::OFF_OL_STAT)
      begin
        if (r.wstrb[0])
          ol_clr = r.wdata[3:0];
      end
      else if (r.waddr == hssc_pkg::OFF_SUP_STAT)
      begin
        if (r.wstrb[0])
          sup_clr = r.wdata[1:0];
      end
      else if (r.waddr != hssc_pkg::OFF_STATE)
        n.bresp = hssc_pkg::RESP_SLVERR;
    end

    // PWM generators run free so an assignment shows PWM at once
    for (int g = 0; g < 2; g++)
    begin
      step_lim = r.freq_fast[g] ? hssc_pkg::PWM_FAST_STEP_CYC
                                : hssc_pkg::PWM_SLOW_STEP_CYC;
      if (r.pre[g] >= step_lim - 12'h001)
      begin
        n.pre[g]  = 12'h000;
        n.step[g] = r.step[g] + 8'h01;
      end
      else
        n.pre[g] = r.pre[g] + 12'h001;
      n.pwm_out[g] = (r.step[g] < r.duty[g]);
    end

    // Supply faults; events flag only their own bit, set wins over clear
    fault = (r.ov_s[1] && r.sup_cfg[hssc_pkg::SUP_OV_EN_BIT]) ||
            (r.uv_s[1] && r.sup_cfg[hssc_pkg::SUP_UV_EN_BIT]);
    n.fault_q = fault;
    n.sup_flag[hssc_pkg::SUP_OV_FLAG_BIT] =
      (r.sup_flag[hssc_pkg::SUP_OV_FLAG_BIT] &&
       !sup_clr[hssc_pkg::SUP_OV_FLAG_BIT]) || r.ov_s[1];
    n.sup_flag[hssc_pkg::SUP_UV_FLAG_BIT] =
      (r.sup_flag[hssc_pkg::SUP_UV_FLAG_BIT] &&
       !sup_clr[hssc_pkg::SUP_UV_FLAG_BIT]) || r.uv_s[1];
    // Outputs are held off in the clearing cycle too, else the old
    // setup would pulse them once after the fault goes away
    wipe = r.fault_q && !fault && !r.sup_cfg[hssc_pkg::SUP_REC_EN_BIT];
    if (wipe)
      n.cfg = '0;

    for (int i = 0; i < 4; i++)
    begin
      // Filters only count a continuous indication on a driven output
      if (r.oc_s[1][i] && r.out[i])
      begin
        if (r.oc_cnt[i] >= oc_lim)
        begin
          n.oc_cnt[i] = '0;
          n.cfg[i]    = hssc_pkg::CFG_OFF;
        end
        else
          n.oc_cnt[i] = r.oc_cnt[i] + 11'h001;
      end
      else
        n.oc_cnt[i] = '0;
      n.oc_flag[i] = (r.oc_flag[i] && !oc_clr[i]) ||
                     (r.oc_s[1][i] && r.out[i] &&
                      r.oc_cnt[i] >= oc_lim);

      if (r.uc_s[1][i] && r.out[i])
      begin
        if (r.ol_cnt[i] < ol_lim)
          n.ol_cnt[i] = r.ol_cnt[i] + 13'h0001;
      end
      else
        n.ol_cnt[i] = '0;
      n.ol_flag[i] = (r.ol_flag[i] && !ol_clr[i]) ||
                     (r.uc_s[1][i] && r.out[i] &&
                      r.ol_cnt[i] >= ol_lim);
    end

    // Restart/Fail-Safe wipes the setup; Normal writes can restore it
    if (forced)
      n.cfg = '0;

    for (int i = 0; i < 4; i++)
    begin
      case (r.cfg[i])
        hssc_pkg::CFG_ON:   src = 1'b1;
        hssc_pkg::CFG_TMR1: src = i_timer1;
        hssc_pkg::CFG_TMR2: src = i_timer2;
        hssc_pkg::CFG_PWM1: src = r.pwm_out[0];
        hssc_pkg::CFG_PWM2: src = r.pwm_out[1];
        default:            src = 1'b0;
      endcase
      // Stop and Sleep keep driving; only faults and forced modes gate
      n.out[i] = src && !fault && !forced && !wipe;
    end

    // Bus read, one outstanding
    if (r.rvalid && i_s_axi_rready)
      n.rvalid = 1'b0;
    if (i_s_axi_arvalid && r.arrdy)
    begin
      n.rvalid = 1'b1;
      n.rresp  = hssc_pkg::RESP_OKAY;
      n.rdata  = 32'h0000_0000;
      if (raddr == hssc_pkg::OFF_CTRL_A)
        n.rdata[6:0] = {r.cfg[1], 1'b0, r.cfg[0]};
      else if (raddr == hssc_pkg::OFF_CTRL_B)
        n.rdata[6:0] = {r.cfg[3], 1'b0, r.cfg[2]};
      else if (raddr == hssc_pkg::OFF_SUP_CFG)
        n.rdata[2:0] = r.sup_cfg;
      else if (raddr == hssc_pkg::OFF_DUTY1)
        n.rdata[7:0] = r.duty[0];
      else if (raddr == hssc_pkg::OFF_DUTY2)
        n.rdata[7:0] = r.duty[1];
      else if (raddr == hssc_pkg::OFF_FREQ)
        n.rdata[1:0] = r.freq_fast;
      else if (raddr == hssc_pkg::OFF_OC_STAT)
        n.rdata[3:0] = r.oc_flag;
      else if (raddr == hssc_pkg::OFF_OL_STAT)
        n.rdata[3:0] = r.ol_flag;
      else if (raddr == hssc_pkg::OFF_SUP_STAT)
        n.rdata[1:0] = r.sup_flag;
      else if (raddr == hssc_pkg::OFF_STATE)
      begin
        n.rdata[3:0] = r.out;
        n.rdata[hssc_pkg::STATE_FAULT_BIT] = r.fault_q;
        n.rdata[hssc_pkg::STATE_LOCK_BIT]  = !normal;
      end
      else
        n.rresp = hssc_pkg::RESP_SLVERR;
    end

    n.awrdy = !n.aw_got && !n.bvalid;
    n.wrdy  = !n.w_got && !n.bvalid;
    n.arrdy = !n.rvalid;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r         <= '0;
      r.sup_cfg <= hssc_pkg::SUP_CFG_RST;
      r.duty    <= {hssc_pkg::DUTY_RST, hssc_pkg::DUTY_RST};
      r.awrdy   <= 1'b1;
      r.wrdy    <= 1'b1;
      r.arrdy   <= 1'b1;
    end
    else
      r <= n;
  end

  assign o_switched_output = r.out;
  assign o_s_axi_awready   = r.awrdy;
  assign o_s_axi_wready    = r.wrdy;
  assign o_s_axi_bresp     = r.bresp;
  assign o_s_axi_bvalid    = r.bvalid;
  assign o_s_axi_arready   = r.arrdy;
  assign o_s_axi_rdata     = r.rdata;
  assign o_s_axi_rresp     = r.rresp;
  assign o_s_axi_rvalid    = r.rvalid;

endmodule : hssc_top

//--- testbench/hssc_properties.sv
`timescale 1ns/1ps
module hssc_props (
  input wire logic                 i_clk,
  input wire logic                 i_rst_n,
  input wire hssc_pkg::hssc_mode_t i_dev_mode,
  input wire logic                 i_supply_ov,
  input wire logic                 i_supply_uv,
  input wire logic [3:0]           i_overcurrent,
  input wire logic [3:0]           o_switched_output,
  input wire logic                 i_s_axi_awvalid,
  input wire logic                 o_s_axi_awready,
  input wire logic                 i_s_axi_wvalid,
  input wire logic                 o_s_axi_wready,
  input wire logic                 o_s_axi_bvalid,
  input wire logic                 i_s_axi_bready,
  input wire logic                 i_s_axi_arvalid,
  input wire logic                 o_s_axi_arready,
  input wire logic                 o_s_axi_rvalid,
  input wire logic [31:0]          o_s_axi_rdata,
  input wire logic                 i_s_axi_rready
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  localparam int OC_LIM = 2010;
  logic [11:0] oc_cnt_r;
  // Raw count on ch3; margin absorbs the two sync stages and the flag edge
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      oc_cnt_r <= 12'h000;
    else
      oc_cnt_r <= (i_overcurrent[2] && o_switched_output[2]) ?
                  oc_cnt_r + 12'h001 : 12'h000;
  sequence wr_taken;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  sequence wr_answer;
    !o_s_axi_awready ##1 o_s_axi_bvalid;
  endsequence
  mode_off_a: assert property (
    (i_dev_mode inside {hssc_pkg::MODE_RESTART, hssc_pkg::MODE_FAILSAFE})[*4]
    |-> o_switched_output == 4'h0)
    else $error("output on in restart or fail-safe");
  ov_off_a: assert property (
    i_supply_ov[*4] |-> o_switched_output == 4'h0)
    else $error("output on during supply overvoltage");
  uv_off_a: assert property (
    i_supply_uv[*4] |-> o_switched_output == 4'h0)
    else $error("output on during supply undervoltage");
  oc_trip_a: assert property (oc_cnt_r < OC_LIM)
    else $error("output kept on through overcurrent");
  wr_resp_a: assert property (wr_taken |=> wr_answer)
    else $error("write response late");
  rd_resp_a: assert property (i_s_axi_arvalid && o_s_axi_arready
    |=> o_s_axi_rvalid && !o_s_axi_arready)
    else $error("read answer late");
  rd_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready
    |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read answer dropped");
  b_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready
    |=> o_s_axi_bvalid)
    else $error("write response dropped");
endmodule : hssc_props

//--- testbench/hssc_load_model.sv
`timescale 1ns/1ps
module hssc_load_model (
  input  wire logic [3:0] i_drive,
  input  wire logic [3:0] i_short,
  input  wire logic [3:0] i_open,
  output logic      [3:0] o_overcurrent,
  output logic      [3:0] o_undercurrent
);
  // Current flows only while the switch conducts, so both
  // indications drop in every PWM off phase
  assign o_overcurrent  = i_drive & i_short;
  assign o_undercurrent = i_drive & i_open;
endmodule : hssc_load_model

//--- testbench/hssc_top_tb.sv
`timescale 1ns/1ps
module hssc_top_tb;
  logic                 clk = 1'b0, rst_n = 1'b0;
  hssc_pkg::hssc_mode_t mode = hssc_pkg::MODE_NORMAL;
  logic                 ov = 1'b0, uv = 1'b0, t1 = 1'b0, t2 = 1'b0;
  logic [3:0]           sw, oc, uc, shrt = '0, opn = '0;
  logic [7:0]           awa = '0, ara = '0, d;
  logic [31:0]          wd = '0, rdat;
  logic                 awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic                 awr, wrr, bv, arr, rv;
  logic [1:0]           bresp, rresp;
  int                   miscompares = 0, compares = 0, cycles = 0, lo, lo4;
  hssc_top #(.P_OL_FILT_CYC(20)) DUT (
    .i_clk(clk), .i_rst_n(rst_n), .i_dev_mode(mode), .i_supply_ov(ov),
    .i_supply_uv(uv), .i_overcurrent(oc), .i_undercurrent(uc),
    .i_timer1(t1), .i_timer2(t2), .o_switched_output(sw),
    .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wrr), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(br), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arr), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rr));
  hssc_load_model u_load (.i_drive(sw), .i_short(shrt), .i_open(opn),
    .o_overcurrent(oc), .o_undercurrent(uc));
  always #4 clk = ~clk;
  task automatic finish_test();
    if (miscompares == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares = miscompares + 1;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares = compares + 1;
    if (s !== e)
    begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Ready for the answer stands from the request on; the answer is
  // taken at the edge that shows it
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er = hssc_pkg::RESP_OKAY);
    logic [1:0] p;
    p = 2'b11;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (p !== 2'b00)
    begin
      @(posedge clk);
      if (awr === 1'b1)
        p[1] = 1'b0;
      if (wrr === 1'b1)
        p[0] = 1'b0;
      awv <= p[1];
      wv <= p[0];
    end
    do @(posedge clk); while (bv !== 1'b1);
    chk(bresp, er);
    br <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = hssc_pkg::RESP_OKAY);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    chk(rdat, e);
    chk(rresp, er);
    rr <= 1'b0;
    @(posedge clk);
  endtask : rd
  // Duties are zero while this is used, so PWM codes read as off
  function automatic logic exp_src(input logic [2:0] c, input logic a,
                                   input logic b);
    case (c)
      3'h1: exp_src = 1'b1;
      3'h2: exp_src = a;
      3'h3: exp_src = b;
      default: exp_src = 1'b0;
    endcase
  endfunction : exp_src
  initial
  begin
    void'($urandom(32'hbc84cd1f));
    cyc(10);
    rst_n <= 1'b1;
    cyc(1);
    rd(hssc_pkg::OFF_SUP_CFG, 32'h3);
    rd(hssc_pkg::OFF_CTRL_A, 32'h0);
    rd(8'h40, 32'h0, hssc_pkg::RESP_SLVERR);
    wr(8'h40, 32'h0, hssc_pkg::RESP_SLVERR);
    for (int i = 0; i < 16; i++)
    begin
      {t1, t2} <= 2'($urandom);
      wr(hssc_pkg::OFF_CTRL_A, 32'(i % 8));
      cyc(4);
      chk(sw[0], exp_src(3'(i), t1, t2));
      t1 <= ~t1;
      t2 <= ~t2;
      cyc(4);
      chk(sw[0], exp_src(3'(i), t1, t2));
    end
    d = 8'($urandom_range(255, 3));
    wr(hssc_pkg::OFF_DUTY1, 32'(d));
    rd(hssc_pkg::OFF_DUTY1, 32'(d));
    wr(hssc_pkg::OFF_DUTY1, 32'h0);
    wr(hssc_pkg::OFF_DUTY2, 32'hff);
    wr(hssc_pkg::OFF_FREQ, 32'h2);
    rd(hssc_pkg::OFF_FREQ, 32'h2);
    wr(hssc_pkg::OFF_CTRL_A, 32'h50);
    wr(hssc_pkg::OFF_CTRL_B, 32'h54);
    lo = 0;
    lo4 = 0;
    repeat (4000)
    begin
      @(posedge clk);
      if (sw[1] !== 1'b1)
        lo = lo + 1;
      if (sw[3] !== 1'b1)
        lo4 = lo4 + 1;
      chk(sw[2], 1'b0);
    end
    // At most step 255 of one fast period may be low
    chk(lo <= 1224, 1'b1);
    chk(lo4 <= 1224, 1'b1);
    wr(hssc_pkg::OFF_CTRL_B, 32'h1);
    shrt[2] <= 1'b1;
    cyc(1500);
    shrt[2] <= 1'b0;
    cyc(4);
    shrt[2] <= 1'b1;
    cyc(1990);
    chk(sw[2], 1'b1);
    cyc(20);
    chk(sw[2], 1'b0);
    rd(hssc_pkg::OFF_CTRL_B, 32'h0);
    rd(hssc_pkg::OFF_OC_STAT, 32'h4);
    rd(hssc_pkg::OFF_SUP_STAT, 32'h0);
    shrt[2] <= 1'b0;
    cyc(8);
    rd(hssc_pkg::OFF_OC_STAT, 32'h4);
    wr(hssc_pkg::OFF_OC_STAT, 32'h4);
    wr(hssc_pkg::OFF_CTRL_B, 32'h1);
    cyc(2);
    chk(sw[2], 1'b1);
    rd(hssc_pkg::OFF_OC_STAT, 32'h0);
    wr(hssc_pkg::OFF_CTRL_A, 32'h51);
    opn[0] <= 1'b1;
    cyc(32);
    chk(sw[0], 1'b1);
    rd(hssc_pkg::OFF_OL_STAT, 32'h1);
    opn[0] <= 1'b0;
    cyc(4);
    rd(hssc_pkg::OFF_OL_STAT, 32'h1);
    wr(hssc_pkg::OFF_OL_STAT, 32'h1);
    rd(hssc_pkg::OFF_OL_STAT, 32'h0);
    wr(hssc_pkg::OFF_SUP_CFG, 32'h7);
    mode <= hssc_pkg::MODE_STOP;
    wr(hssc_pkg::OFF_CTRL_A, 32'h0);
    rd(hssc_pkg::OFF_CTRL_A, 32'h51);
    mode <= hssc_pkg::MODE_SLEEP;
    ov <= 1'b1;
    cyc(5);
    chk(sw, 4'h0);
    rd(hssc_pkg::OFF_STATE, 32'h30);
    rd(hssc_pkg::OFF_SUP_STAT, 32'h1);
    rd(hssc_pkg::OFF_OC_STAT, 32'h0);
    ov <= 1'b0;
    cyc(5);
    chk(sw[0] & sw[2], 1'b1);
    mode <= hssc_pkg::MODE_NORMAL;
    wr(hssc_pkg::OFF_SUP_STAT, 32'h3);
    wr(hssc_pkg::OFF_SUP_CFG, 32'h3);
    uv <= 1'b1;
    cyc(5);
    chk(sw, 4'h0);
    uv <= 1'b0;
    repeat (6)
    begin
      @(posedge clk);
      chk(sw, 4'h0);
    end
    rd(hssc_pkg::OFF_CTRL_A, 32'h0);
    for (int k = 0; k < 2; k++)
    begin
      wr(hssc_pkg::OFF_CTRL_A, 32'h1);
      mode <= k ? hssc_pkg::MODE_FAILSAFE : hssc_pkg::MODE_RESTART;
      cyc(4);
      chk(sw[0], 1'b0);
      mode <= hssc_pkg::MODE_NORMAL;
      cyc(2);
      wr(hssc_pkg::OFF_CTRL_A, 32'h1);
      cyc(2);
      chk(sw[0], 1'b1);
    end
    finish_test();
  end
endmodule : hssc_top_tb
bind hssc_top hssc_props u_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_dev_mode(i_dev_mode),
  .i_supply_ov(i_supply_ov), .i_supply_uv(i_supply_uv),
  .i_overcurrent(i_overcurrent), .o_switched_output(o_switched_output),
  .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
  .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
  .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
  .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_rvalid(o_s_axi_rvalid), .o_s_axi_rdata(o_s_axi_rdata),
  .i_s_axi_rready(i_s_axi_rready));
